// ---- irq_expander_pkg.sv ----
// shared constants and carrier types for the peripheral interrupt expander
package irq_expander_pkg;
   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int REQ_COUNT = 96;
   localparam int GROUP_SIZE = 8;
   localparam int GROUP_COUNT = 12;
   localparam int REQ_IDX_W = 7;
   localparam int GROUP_IDX_W = 4;
   localparam int SLOT_IDX_W = 3;
   localparam int VECTOR_W = 22;

   // ***************************************************************
   // positions wired to peripheral sources: bits 0..42 (43 of 96)
   // ***************************************************************
   localparam logic [95:0] CONNECTED_MASK = 96'h0000_0000_0000_07FF_FFFF_FFFF;

   // ***************************************************************
   // reset values
   // ***************************************************************
   localparam logic [21:0] VECTOR_RESET = 22'h00_0000;
   localparam logic [95:0] PENDING_RESET = 96'h0;

   // service acknowledge from the processor core
   typedef struct packed {
      logic valid;
      logic [3:0] line;
   } service_ack_t;

   // vector handed to the processor core
   typedef struct packed {
      logic valid;
      logic [6:0] source;
      logic [21:0] vector;
   } vector_fetch_t;

   // software write into the vector table
   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [21:0] data;
   } vector_write_t;
endpackage : irq_expander_pkg

// ---- irq_group_select.sv ----
// fixed-priority pick of one group of eight requests
`timescale 1ns/1ps
module irq_group_select (
   input wire logic [7:0] active_i,
   output logic any_o,
   output logic [2:0] slot_o
);
   always_comb begin
      any_o = |active_i;
      slot_o = 3'h0;
      // walk downward so the lowest active slot is the last written
      for (int i = 7; i >= 0; i--) begin
         if (active_i[i]) begin
            slot_o = 3'(i);
         end
      end
   end
endmodule : irq_group_select

// ---- peripheral_interrupt_expander.sv ----
// peripheral interrupt expander: 96 requests onto 12 processor lines
// Notes on behaviour
// - up to 96 peripheral request inputs funnel onto fewer processor lines.
// - requests form groups of eight, each group drives one of twelve lines.
// - only 43 positions are connected; the rest stay inactive.
// - every position has its own vector in a writable vector table.
// - on service the winning request's vector is supplied to the processor.
// - fixed hardware priority, shaped by software through the enables.
// - each position has its own enable; disabled requests never reach lines.
`timescale 1ns/1ps
module peripheral_interrupt_expander (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [95:0] periph_req_i,
   input wire logic [95:0] req_enable_i,
   input wire irq_expander_pkg::vector_write_t vec_write_i,
   input wire irq_expander_pkg::service_ack_t service_ack_i,
   output logic cpu_irq_line_first_o,
   output logic [9:0] cpu_irq_line_mid_o,
   output logic cpu_irq_line_last_o,
   output irq_expander_pkg::vector_fetch_t vector_fetch_o,
   output logic [95:0] pending_o
);
   // ***************************************************************
   // request synchroniser
   // ***************************************************************
   logic [95:0] req_meta;
   logic [95:0] req_sync;
   logic [95:0] req_prev;
   logic [95:0] req_rise;

   // requests are asynchronous pins; only the second stage reads the first
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_meta <= 96'h0;
      end else begin
         req_meta <= periph_req_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_sync <= 96'h0;
      end else begin
         req_sync <= req_meta;
      end
   end

   // ***************************************************************
   // edge capture
   // ***************************************************************
   // history resets to the idle pin level, so leaving reset makes no edge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_prev <= 96'h0;
      end else begin
         req_prev <= req_sync;
      end
   end

   // a level held high counts once; it must drop before it can pend again
   // masking after the synchroniser keeps logic off the raw pins
   assign req_rise = req_sync & ~req_prev
      & irq_expander_pkg::CONNECTED_MASK;

   // ***************************************************************
   // acknowledge decode
   // ***************************************************************
   logic [11:0] group_any;
   logic [2:0] group_slot [12];
   logic ack_line_ok;
   logic ack_hit;
   logic [2:0] ack_slot;
   logic [6:0] ack_winner;

   // line codes 12 to 15 name no group and are ignored
   assign ack_line_ok = service_ack_i.line <
      4'(irq_expander_pkg::GROUP_COUNT);

   // an acknowledge for a group with nothing enabled and pending is dropped
   always_comb begin
      ack_hit = 1'b0;
      ack_slot = 3'h0;
      if (service_ack_i.valid && ack_line_ok) begin
         ack_hit = group_any[service_ack_i.line];
         ack_slot = group_slot[service_ack_i.line];
      end
   end

   // position p sits in group p/8 at slot p%8
   assign ack_winner = {service_ack_i.line, ack_slot};

   // ***************************************************************
   // pending flags
   // ***************************************************************
   logic [95:0] clear_onehot;
   logic [95:0] next_pending;
   logic [95:0] pending;

   always_comb begin
      clear_onehot = 96'h0;
      if (ack_hit) begin
         clear_onehot[ack_winner] = 1'b1;
      end
   end

   // the set is applied after the clear, so an edge in the clearing
   // cycle wins and no event is lost
   always_comb begin
      next_pending = pending & ~clear_onehot;
      next_pending = next_pending | req_rise;
      next_pending = next_pending & irq_expander_pkg::CONNECTED_MASK;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pending <= irq_expander_pkg::PENDING_RESET;
      end else begin
         pending <= next_pending;
      end
   end

   // ***************************************************************
   // enable gating and per-group priority
   // ***************************************************************
   logic [95:0] active;

   // enables gate only propagation; a masked request stays pending
   assign active = pending & req_enable_i;

   for (genvar g = 0; g < irq_expander_pkg::GROUP_COUNT; g++) begin : grp
      irq_group_select u_sel (
         .active_i(active[g*8 +: 8]),
         .any_o(group_any[g]),
         .slot_o(group_slot[g])
      );
   end

   // ***************************************************************
   // processor interrupt lines
   // ***************************************************************
   logic [11:0] irq_lines;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_lines <= 12'h000;
      end else begin
         irq_lines <= group_any;
      end
   end

   // ***************************************************************
   // vector table
   // ***************************************************************
   logic [21:0] vector_table [96];
   logic write_hit;

   // writes past the last position are dropped rather than wrapped
   assign write_hit = vec_write_i.valid &&
      vec_write_i.addr < 7'(irq_expander_pkg::REQ_COUNT);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < irq_expander_pkg::REQ_COUNT; i++) begin
            vector_table[i] <= irq_expander_pkg::VECTOR_RESET;
         end
      end else if (write_hit) begin
         vector_table[vec_write_i.addr] <= vec_write_i.data;
      end
   end

   // ***************************************************************
   // vector fetch answer
   // ***************************************************************
   logic fetch_valid;
   logic [6:0] fetch_source;
   logic [21:0] fetch_vector;

   // answer one cycle after the acknowledge, well inside the fetch budget
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fetch_valid <= 1'b0;
      end else begin
         fetch_valid <= ack_hit;
      end
   end

   // source and vector hold until the next accepted acknowledge
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fetch_source <= 7'h00;
      end else if (ack_hit) begin
         fetch_source <= ack_winner;
      end
   end

   // a write to the winning entry in the same cycle shows at the next service
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         fetch_vector <= irq_expander_pkg::VECTOR_RESET;
      end else if (ack_hit) begin
         fetch_vector <= vector_table[ack_winner];
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign pending_o = pending;

   assign cpu_irq_line_first_o = irq_lines[0];
   assign cpu_irq_line_mid_o = irq_lines[10:1];
   assign cpu_irq_line_last_o = irq_lines[11];

   assign vector_fetch_o = '{
      valid: fetch_valid,
      source: fetch_source,
      vector: fetch_vector
   };
endmodule : peripheral_interrupt_expander

// ---- irq_expander_monitor.sv ----
// port checker for the peripheral interrupt expander
`timescale 1ns/1ps
module irq_expander_monitor (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [95:0] periph_req_i,
   input wire logic [95:0] req_enable_i,
   input wire irq_expander_pkg::service_ack_t service_ack_i,
   input wire logic cpu_irq_line_first_o,
   input wire logic [9:0] cpu_irq_line_mid_o,
   input wire logic cpu_irq_line_last_o,
   input wire irq_expander_pkg::vector_fetch_t vector_fetch_o,
   input wire logic [95:0] pending_o
);
   logic [95:0] act;
   logic [11:0] grp;
   logic [11:0] ln;
   logic [6:0] s;
   assign act = pending_o & req_enable_i;
   assign ln = {cpu_irq_line_last_o, cpu_irq_line_mid_o, cpu_irq_line_first_o};
   assign s = vector_fetch_o.source;
   always_comb begin
      for (int g = 0; g < 12; g++) begin
         grp[g] = |act[g*8 +: 8];
      end
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   chk_unused_idle: assert property (
      pending_o[95:43] == '0) else $error("unused position pending");
   chk_line_group: assert property (
      ln == $past(grp)) else $error("line does not follow group");
   chk_pend_rise: assert property (
      $rose(periph_req_i[1]) |-> ##3 pending_o[1]) else $error("no pend");
   chk_pend_cause: assert property (
      $rose(pending_o[5]) |-> $past(periph_req_i[5], 3)) else $error("pend");
   chk_ack_taken: assert property (
      service_ack_i.valid && grp[service_ack_i.line] |=> vector_fetch_o.valid)
      else $error("ack not answered");
   chk_fetch_cause: assert property (
      vector_fetch_o.valid |-> $past(service_ack_i.valid)
      && s[6:3] == $past(service_ack_i.line)) else $error("stray fetch");
   chk_low_wins: assert property (
      vector_fetch_o.valid |-> ($past(act) & (96'h1 << s)) != '0
      && ($past(act) & (96'hFF << {s[6:3], 3'h0}) & ((96'h1 << s) - 96'h1))
      == '0) else $error("wrong winner");
   chk_ack_clears: assert property (
      vector_fetch_o.valid |-> !pending_o[s]) else $error("pend not cleared");
endmodule : irq_expander_monitor

// ---- cpu_core_model.sv ----
// processor core model that takes expanded lines and acknowledges them
`timescale 1ns/1ps
module cpu_core_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic serve_i,
   input wire logic [11:0] lines_i,
   output irq_expander_pkg::service_ack_t ack_o
);
   int busy = 0;
   int pick;
   irq_expander_pkg::service_ack_t next_ack;
   initial ack_o = '0;
   always @(posedge core_clk_i) begin
      #1;
      next_ack = '0;
      pick = -1;
      for (int i = 11; i >= 0; i--) begin
         if (lines_i[i]) pick = i;
      end
      // busy spans fetch and context save, so a stale line is not retaken
      if (rst_i) busy = 0;
      else if (busy > 0) busy--;
      else if (serve_i && pick >= 0) begin
         next_ack = '{1'b1, 4'(pick)};
         busy = 8;
      end
      // one assignment per cycle keeps the acknowledge a clean pulse
      ack_o = next_ack;
   end
endmodule : cpu_core_model

// ---- peripheral_interrupt_expander_bench.sv ----
// self-checking bench for the peripheral interrupt expander
`timescale 1ns/1ps
module peripheral_interrupt_expander_bench;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic serve = 1'b0;
   logic [95:0] periph_req_i = '0;
   logic [95:0] req_enable_i = '0;
   irq_expander_pkg::vector_write_t vec_write_i = '0;
   irq_expander_pkg::service_ack_t service_ack_i;
   logic cpu_irq_line_first_o;
   logic [9:0] cpu_irq_line_mid_o;
   logic cpu_irq_line_last_o;
   irq_expander_pkg::vector_fetch_t vector_fetch_o;
   logic [95:0] pending_o;
   logic [11:0] ln;
   logic [6:0] src [4] = '{7'h01, 7'h05, 7'h09, 7'h2A};
   logic [21:0] vec [4] = '{22'h0001C0, 22'h0A0505, 22'h000909, 22'h3C2A2A};
   int err_total = 0;
   int comparisons = 0;
   assign ln = {cpu_irq_line_last_o, cpu_irq_line_mid_o, cpu_irq_line_first_o};
   always #10 core_clk_i = ~core_clk_i;
   peripheral_interrupt_expander u_peripheral_interrupt_expander (.*);
   cpu_core_model u_cpu_core_model (.core_clk_i, .rst_i, .serve_i(serve),
      .lines_i(ln), .ack_o(service_ack_i));
   task step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step
   task chk(input string n, input logic [95:0] e, input logic [95:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wr(input logic [6:0] a, input logic [21:0] d);
      vec_write_i = {1'b1, a, d};
      step(1);
      vec_write_i = '0;
      step(1);
   endtask : wr
   task serve_one(input logic [6:0] s, input logic [21:0] v);
      serve = 1'b1;
      for (int i = 0; i < 30 && vector_fetch_o.valid !== 1'b1; i++)
         @(negedge core_clk_i);
      chk("fetch", 1'b1, vector_fetch_o.valid);
      chk("source", s, vector_fetch_o.source);
      chk("vector", v, vector_fetch_o.vector);
      step(1);
      serve = 1'b0;
      step(1);
   endtask : serve_one
   task summarize;
      $display("comparisons %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial begin
      #100000;
      err_total++;
      summarize();
   end
   initial begin
      step(20);
      rst_i = 1'b0;
      chk("pending", '0, pending_o);
      chk("lines", '0, ln);
      $display("test reset done");
      wr(7'h05, 22'h155555);
      foreach (src[i]) wr(src[i], vec[i]);
      wr(7'h64, 22'h3FFFFF);
      $display("test table done");
      req_enable_i = ~(96'h1 << 42);
      periph_req_i = 96'h400_0000_0222 | (96'h1 << 50);
      step(3);
      periph_req_i = '0;
      step(4);
      chk("pending", 96'h400_0000_0222, pending_o);
      chk("lines", 12'h003, ln);
      $display("test pend done");
      for (int i = 0; i < 3; i++) serve_one(src[i], vec[i]);
      step(2);
      chk("pending", 96'h1 << 42, pending_o);
      chk("lines", '0, ln);
      req_enable_i = '1;
      step(3);
      chk("lines", 12'h020, ln);
      serve_one(src[3], vec[3]);
      step(2);
      chk("pending", '0, pending_o);
      $display("test serve done");
      summarize();
   end
endmodule : peripheral_interrupt_expander_bench
bind peripheral_interrupt_expander irq_expander_monitor u_irq_expander_monitor (.*);
